/* File: design/emb_mult_pkg.sv */
// Purpose: shared constants of the embedded multiplier block
// Assumes: one clock, registers reached over a 32-bit APB slave
// Notes: holds widths, register offsets, field positions and reset values

package emb_mult_pkg;

  // ---------------------------------------------------------------
  // datapath widths
  // ---------------------------------------------------------------
  localparam int OPND_W = 18;
  localparam int HALF_W = 9;
  localparam int PROD_W = 36;
  localparam int SECT_W = 18;

  // ---------------------------------------------------------------
  // register map (byte addresses)
  // ---------------------------------------------------------------
  localparam int ADDR_W = 12;
  localparam logic [11:0] CFG_ADDR = 12'h000;
  localparam logic [11:0] PROD_LO_ADDR = 12'h004;
  localparam logic [11:0] PROD_HI_ADDR = 12'h008;
  localparam logic [11:0] OPND_ADDR = 12'h00c;

  // ---------------------------------------------------------------
  // configuration fields
  // ---------------------------------------------------------------
  localparam int CFG_W = 8;
  localparam int CFG_DUAL_BIT = 0;
  localparam int CFG_REG_A_BIT = 1;
  localparam int CFG_REG_B_BIT = 2;
  localparam int CFG_REG_SA_BIT = 3;
  localparam int CFG_REG_SB_BIT = 4;
  localparam int CFG_REG_OLO_BIT = 5;
  localparam int CFG_REG_OHI_BIT = 6;
  localparam int CFG_SIGN_USED_BIT = 7;
  localparam logic [7:0] CFG_RST = 8'h00;

  // ---------------------------------------------------------------
  // read-back fields
  // ---------------------------------------------------------------
  localparam int PROD_HI_SIGNED_BIT = 8;
  localparam int OPND_SA_BIT = 0;
  localparam int OPND_SB_BIT = 1;
  localparam logic [31:0] RDATA_RST = 32'h0000_0000;
  localparam logic [35:0] PROD_RST = 36'h0_0000_0000;
  localparam logic [17:0] OPND_RST = 18'h0_0000;

endpackage

/* File: design/embedded_multiplier_block.sv */
// Purpose: hard multiplier block, one 18x18 or two 9x9 products
// Assumes: operands, sign selects, mult_ena and mult_clr come from fabric
// Notes: configuration and product read-back over an APB slave
//
// Function
// - one 18x18 or two 9x9 multipliers
// - each operand registered or bypassed separately
// - bypassed operands feed in 9/18-bit sections
// - input registers have clock, enable, clear
// - all registers share clock, enable, clear
// - sign select high means two's-complement operand
// - product unsigned only if both operands unsigned
// - one sign select per operand, shared in dual
// - sign selects may change between multiplications
// - optional input registers for sign selects
// - product always full precision
// - unused sign selects default to unsigned
// - output registered in 18/36-bit sections or combinational
// - output registers have clock, enable, clear
//
// The register offsets and the APB interface to the registers were chosen for this implementation.

`timescale 1ns/1ps
`default_nettype none

module embedded_multiplier_block
  import emb_mult_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // shared multiplier controls
  input wire logic mult_ena,
  input wire logic mult_clr,
  // operands
  input wire logic [OPND_W-1:0] data_a,
  input wire logic [OPND_W-1:0] data_b,
  input wire logic sign_a,
  input wire logic sign_b,
  // result
  output logic [PROD_W-1:0] product,
  output logic product_signed
);

  // -----------------------------------------------------------------
  // declarations
  // -----------------------------------------------------------------
  logic [CFG_W-1:0] cfg_r;
  logic [31:0] prdata_r;
  logic pready_r;
  logic pslverr_r;
  logic [OPND_W-1:0] a_in_r;
  logic [OPND_W-1:0] b_in_r;
  logic sa_in_r;
  logic sb_in_r;
  logic [PROD_W-1:0] out_r;
  logic sgn_lo_r;
  logic sgn_hi_r;

  logic mode_dual;
  logic sign_used;
  logic [OPND_W-1:0] a_op;
  logic [OPND_W-1:0] b_op;
  logic sa_eff;
  logic sb_eff;
  logic [PROD_W-1:0] prod_wide;
  logic [SECT_W-1:0] prod_lo;
  logic [SECT_W-1:0] prod_hi;
  logic [PROD_W-1:0] prod_comb;
  logic prod_sgn_comb;
  logic sel_reg_lo;
  logic sel_reg_hi;
  logic [PROD_W-1:0] product_nxt;
  logic product_signed_nxt;

  logic apb_setup_done;
  logic apb_commit;
  logic addr_hit;
  logic [31:0] rdata_nxt;

  assign mode_dual = cfg_r[CFG_DUAL_BIT];
  assign sign_used = cfg_r[CFG_SIGN_USED_BIT];

  // -----------------------------------------------------------------
  // apb slave: one wait state, answer on second access cycle
  // -----------------------------------------------------------------
  assign apb_setup_done = psel & penable & ~pready_r;
  assign apb_commit = psel & penable & pready_r;

  always_comb begin
    addr_hit = 1'b1;
    rdata_nxt = RDATA_RST;
    unique case (paddr)
      CFG_ADDR: begin
        rdata_nxt[CFG_W-1:0] = cfg_r;
      end
      PROD_LO_ADDR: begin
        rdata_nxt = product_nxt[31:0];
      end
      PROD_HI_ADDR: begin
        rdata_nxt[PROD_W-33:0] = product_nxt[PROD_W-1:32];
        rdata_nxt[PROD_HI_SIGNED_BIT] = product_signed_nxt;
      end
      OPND_ADDR: begin
        rdata_nxt[OPND_SA_BIT] = sa_eff;
        rdata_nxt[OPND_SB_BIT] = sb_eff;
      end
      default: begin
        addr_hit = 1'b0;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r <= 1'b0;
    end else begin
      pready_r <= apb_setup_done;
    end
  end

  // error flag stands with pready for one cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr_r <= 1'b0;
    end else if (apb_setup_done) begin
      pslverr_r <= ~addr_hit;
    end else if (apb_commit) begin
      pslverr_r <= 1'b0;
    end
  end

  // read data is taken at the first access edge, zero for writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= RDATA_RST;
    end else if (apb_setup_done) begin
      prdata_r <= (pwrite || !addr_hit) ? RDATA_RST : rdata_nxt;
    end else if (apb_commit) begin
      prdata_r <= RDATA_RST;
    end
  end

  // configuration: only byte lane 0 carries fields
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_r <= CFG_RST;
    end else if (apb_commit && pwrite && paddr == CFG_ADDR && pstrb[0]) begin
      cfg_r <= pwdata[CFG_W-1:0];
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;

  // -----------------------------------------------------------------
  // input registers: shared clock, enable and clear
  // -----------------------------------------------------------------
  // operand a capture, loaded even when bypassed so a mode switch is clean
  always_ff @(posedge pclk or negedge presetn or posedge mult_clr) begin
    if (!presetn || mult_clr) begin
      a_in_r <= OPND_RST;
    end else if (mult_ena) begin
      a_in_r <= data_a;
    end
  end

  // operand b capture
  always_ff @(posedge pclk or negedge presetn or posedge mult_clr) begin
    if (!presetn || mult_clr) begin
      b_in_r <= OPND_RST;
    end else if (mult_ena) begin
      b_in_r <= data_b;
    end
  end

  // -----------------------------------------------------------------
  // sign-select registers: keep signs aligned with registered operands
  // -----------------------------------------------------------------
  // sign of operand a
  always_ff @(posedge pclk or negedge presetn or posedge mult_clr) begin
    if (!presetn || mult_clr) begin
      sa_in_r <= 1'b0;
    end else if (mult_ena) begin
      sa_in_r <= sign_a;
    end
  end

  // sign of operand b
  always_ff @(posedge pclk or negedge presetn or posedge mult_clr) begin
    if (!presetn || mult_clr) begin
      sb_in_r <= 1'b0;
    end else if (mult_ena) begin
      sb_in_r <= sign_b;
    end
  end

  // -----------------------------------------------------------------
  // operand and sign selection
  // -----------------------------------------------------------------
  // each input picks its register or the pin on its own
  always_comb begin
    a_op = data_a;
    if (cfg_r[CFG_REG_A_BIT]) begin
      a_op = a_in_r;
    end
    b_op = data_b;
    if (cfg_r[CFG_REG_B_BIT]) begin
      b_op = b_in_r;
    end
    // unused sign selects leave both operands unsigned
    sa_eff = 1'b0;
    sb_eff = 1'b0;
    if (sign_used) begin
      sa_eff = sign_a;
      sb_eff = sign_b;
      if (cfg_r[CFG_REG_SA_BIT]) begin
        sa_eff = sa_in_r;
      end
      if (cfg_r[CFG_REG_SB_BIT]) begin
        sb_eff = sb_in_r;
      end
    end
  end

  // -----------------------------------------------------------------
  // multiplier stage
  // -----------------------------------------------------------------
  mult_slice #(
    .W(OPND_W)
  ) u_wide (
    .op_a(a_op),
    .op_b(b_op),
    .sgn_a(sa_eff),
    .sgn_b(sb_eff),
    .prod(prod_wide)
  );

  // both narrow multipliers share the one pair of sign selects
  mult_slice #(
    .W(HALF_W)
  ) u_lo (
    .op_a(a_op[HALF_W-1:0]),
    .op_b(b_op[HALF_W-1:0]),
    .sgn_a(sa_eff),
    .sgn_b(sb_eff),
    .prod(prod_lo)
  );

  mult_slice #(
    .W(HALF_W)
  ) u_hi (
    .op_a(a_op[OPND_W-1:HALF_W]),
    .op_b(b_op[OPND_W-1:HALF_W]),
    .sgn_a(sa_eff),
    .sgn_b(sb_eff),
    .prod(prod_hi)
  );

  // full 36-bit result in either mode, never trimmed
  assign prod_comb = mode_dual ? {prod_hi, prod_lo} : prod_wide;
  assign prod_sgn_comb = sa_eff | sb_eff;

  // -----------------------------------------------------------------
  // output registers: 18-bit sections in dual, one 36-bit in single
  // -----------------------------------------------------------------
  // product register, split into sections only by the read-out mux
  always_ff @(posedge pclk or negedge presetn or posedge mult_clr) begin
    if (!presetn || mult_clr) begin
      out_r <= PROD_RST;
    end else if (mult_ena) begin
      out_r <= prod_comb;
    end
  end

  // sign flag seen by the low section
  always_ff @(posedge pclk or negedge presetn or posedge mult_clr) begin
    if (!presetn || mult_clr) begin
      sgn_lo_r <= 1'b0;
    end else if (mult_ena) begin
      sgn_lo_r <= prod_sgn_comb;
    end
  end

  // sign flag seen by the high section
  always_ff @(posedge pclk or negedge presetn or posedge mult_clr) begin
    if (!presetn || mult_clr) begin
      sgn_hi_r <= 1'b0;
    end else if (mult_ena) begin
      sgn_hi_r <= prod_sgn_comb;
    end
  end

  assign sel_reg_lo = cfg_r[CFG_REG_OLO_BIT];
  assign sel_reg_hi = mode_dual ? cfg_r[CFG_REG_OHI_BIT] : cfg_r[CFG_REG_OLO_BIT];

  // a bypassed section passes the product straight through
  always_comb begin
    product_nxt = prod_comb;
    if (sel_reg_lo) begin
      product_nxt[SECT_W-1:0] = out_r[SECT_W-1:0];
    end
    if (sel_reg_hi) begin
      product_nxt[PROD_W-1:SECT_W] = out_r[PROD_W-1:SECT_W];
    end
    product_signed_nxt = sel_reg_lo ? sgn_lo_r : prod_sgn_comb;
    if (mode_dual && sel_reg_hi != sel_reg_lo) begin
      // sections disagree in timing: flag follows the upper one's view too
      product_signed_nxt = (sel_reg_lo ? sgn_lo_r : prod_sgn_comb) | (sel_reg_hi ? sgn_hi_r : prod_sgn_comb);
    end
  end

  assign product = product_nxt;
  assign product_signed = product_signed_nxt;

endmodule

`default_nettype wire

/* File: design/mult_slice.sv */
// Purpose: one full-precision multiplier with per-operand sign select
// Assumes: sign inputs are high for two's-complement operands
// Notes: each operand gets one extra bit so signed and unsigned mix exactly

`timescale 1ns/1ps
`default_nettype none

module mult_slice #(
  parameter int W = 9
) (
  // operands
  input wire logic [W-1:0] op_a,
  input wire logic [W-1:0] op_b,
  input wire logic sgn_a,
  input wire logic sgn_b,
  // result
  output logic [2*W-1:0] prod
);

  // -----------------------------------------------------------------
  // extended multiply
  // -----------------------------------------------------------------
  logic signed [W:0] ext_a;
  logic signed [W:0] ext_b;
  logic signed [2*W+1:0] full;

  always_comb begin
    ext_a = $signed({sgn_a & op_a[W-1], op_a});
    ext_b = $signed({sgn_b & op_b[W-1], op_b});
    full = ext_a * ext_b;
    // the low 2W bits always hold the exact product
    prod = full[2*W-1:0];
  end

endmodule

`default_nettype wire

/* File: testbench/emb_mult_asserts.sv */
// Purpose: port checks of the multiplier block
// Assumes: cfg is mirrored from completed APB writes
// Notes: covers cfg 00, 80 and 26, not the dual modes 81 and bf that the bench also sets
`timescale 1ns/1ps
`default_nettype none
module emb_mult_asserts
  import emb_mult_pkg::*;
(
  // clock, reset, apb
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic pready,
  input wire logic pslverr,
  // datapath
  input wire logic mult_ena,
  input wire logic mult_clr,
  input wire logic [OPND_W-1:0] data_a,
  input wire logic [OPND_W-1:0] data_b,
  input wire logic sign_a,
  input wire logic sign_b,
  input wire logic [PROD_W-1:0] product,
  input wire logic product_signed
);
  logic [7:0] cfg_r;
  wire logic [35:0] pu = data_a * data_b;
  wire logic signed [37:0] ps = $signed({sign_a & data_a[17], data_a}) * $signed({sign_b & data_b[17], data_b});
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      cfg_r <= CFG_RST;
    else if (psel && penable && pready && pwrite && paddr == CFG_ADDR && pstrb[0])
      cfg_r <= pwdata[7:0];
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_wait_state: assert property (psel && !penable |=> !pready ##1 pready)
    else $error("apb answer not after one wait");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_err_map: assert property (pready |-> pslverr == (paddr > OPND_ADDR))
    else $error("pslverr wrong for address");
  a_comb_unsigned: assert property (cfg_r == 8'h00 |-> product == pu && !product_signed)
    else $error("bypass product not unsigned");
  a_signed_prod: assert property (cfg_r == 8'h80 |-> product == ps[35:0])
    else $error("signed product wrong");
  a_signed_flag: assert property (cfg_r == 8'h80 |-> product_signed == (sign_a | sign_b))
    else $error("product sign flag wrong");
  a_latency_two: assert property ((cfg_r == 8'h26 && mult_ena && !mult_clr) [*2] |=> mult_clr || product == $past(pu, 2))
    else $error("registered product not two edges late");
  a_clear_zero: assert property (cfg_r[5] && !cfg_r[0] && mult_clr |-> product == '0)
    else $error("clear left output register set");
  a_hold_ena: assert property (cfg_r[5] && !cfg_r[0] && !mult_ena && !psel |=> mult_clr || $stable(product))
    else $error("output register moved while disabled");
endmodule
bind embedded_multiplier_block emb_mult_asserts u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
  .pwdata, .pstrb, .pready, .pslverr, .mult_ena, .mult_clr, .data_a, .data_b, .sign_a, .sign_b, .product,
  .product_signed);
`default_nettype wire

/* File: testbench/fabric_model.sv */
// Purpose: fabric logic that feeds operands to the block
// Assumes: inputs change just after a rising edge
// Notes: operands are driven at full 18-bit width in every mode
`timescale 1ns/1ps
`default_nettype none
module fabric_model
  import emb_mult_pkg::*;
(
  // clock
  input wire logic pclk,
  // operands and controls
  output logic [OPND_W-1:0] data_a,
  output logic [OPND_W-1:0] data_b,
  output logic sign_a,
  output logic sign_b,
  output logic mult_ena,
  output logic mult_clr
);
  initial {data_a, data_b, sign_a, sign_b, mult_ena, mult_clr} = '0;
  task automatic drive(input logic [17:0] a, b, input logic [1:0] s, input logic en, clr);
    @(posedge pclk);
    data_a <= a;
    data_b <= b;
    sign_a <= s[1];
    sign_b <= s[0];
    mult_ena <= en;
    mult_clr <= clr;
  endtask
endmodule
`default_nettype wire

/* File: testbench/tb_top.sv */
// Purpose: self-checking bench of the multiplier block
// Assumes: one wait state APB slave, fabric model drives operands
// Notes: drivers queue expected values, monitors pop them
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import emb_mult_pkg::*;
;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, look = 0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata;
  logic [3:0] pstrb = 4'hf;
  logic pready, pslverr, sign_a, sign_b, mult_ena, mult_clr, product_signed;
  logic [OPND_W-1:0] data_a, data_b;
  logic [PROD_W-1:0] product;
  logic [36:0] pq[$], rq[$], pe;
  int failures = 0, n_compared = 0, seed = 54961;
  logic [7:0] cfgs[5] = '{8'h00, 8'h80, 8'h81, 8'hbf, 8'h26};
  always #5 pclk = ~pclk;
  embedded_multiplier_block dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata,
    .pready, .pslverr, .mult_ena, .mult_clr, .data_a, .data_b, .sign_a, .sign_b, .product, .product_signed);
  fabric_model fab (.pclk, .data_a, .data_b, .sign_a, .sign_b, .mult_ena, .mult_clr);
  // --------------------------------
  // compare, verdict, monitors
  // --------------------------------
  task automatic chk(input string nm, input logic [36:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic conclude(input bit hung);
    if (hung) failures++;
    $display("compared %0d failed %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  always @(negedge pclk)
    if (look) chk("product", {product_signed, product}, pq.pop_front());
  always @(posedge pclk)
    if (psel && penable && pready) chk("apb", {pslverr, prdata & {32{!pwrite}}}, rq.pop_front());
  initial #500000 conclude(1);
  // --------------------------------
  // drivers
  // --------------------------------
  function automatic logic [36:0] ex(input logic [17:0] a, b, input logic [1:0] s, input logic d);
    logic signed [37:0] p;
    logic signed [19:0] l, h;
    p = $signed({s[1] & a[17], a}) * $signed({s[0] & b[17], b});
    l = $signed({s[1] & a[8], a[8:0]}) * $signed({s[0] & b[8], b[8:0]});
    h = $signed({s[1] & a[17], a[17:9]}) * $signed({s[0] & b[17], b[17:9]});
    return d ? {|s, h[17:0], l[17:0]} : {|s, p[35:0]};
  endfunction
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [32:0] e);
    int i;
    rq.push_back(e);
    @(posedge pclk);
    look <= 0;
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    for (i = 0; i < 20; i++) begin
      @(posedge pclk);
      if (pready) break;
    end
    if (i == 20) conclude(1);
    psel <= 0;
    penable <= 0;
  endtask
  task automatic op(input logic [17:0] a, b, input logic [1:0] s, input logic en, clr, input int lat,
                    input logic [36:0] e);
    fab.drive(a, b, s, en, clr);
    pq.push_back(e);
    if (lat > 0) begin
      look <= 0;
      repeat (lat) @(posedge pclk);
    end
    look <= 1;
  endtask
  // --------------------------------
  // main sequence
  // --------------------------------
  initial begin
    logic [17:0] a, b;
    logic [7:0] c;
    repeat (12) @(posedge pclk);
    presetn <= 1;
    apb(0, CFG_ADDR, 0, 33'h0);
    apb(1, 12'h010, 32'h0000_00ff, {1'b1, 32'h0});
    for (int k = 0; k < 5; k++) begin
      c = cfgs[k];
      apb(1, CFG_ADDR, {24'h0, c}, 33'h0);
      for (int i = 0; i < 8; i++) begin
        a = i == 0 ? 18'h2_0000 : 18'($random(seed));
        b = i == 0 ? 18'h3_ffff : 18'($random(seed));
        op(a, b, i[1:0], 1, 0, c[1] + c[5], ex(a, b, c[7] ? i[1:0] : 2'b00, c[0]));
      end
      $display("test cfg %h done", c);
    end
    pe = ex(a, b, 2'b00, 0);
    op(~a, ~b, 2'b11, 0, 0, 2, pe);
    op(a, b, 2'b00, 0, 1, 0, 37'h0);
    apb(0, PROD_LO_ADDR, 0, 33'h0);
    op(b, a, 2'b00, 1, 0, 2, ex(b, a, 2'b00, 0));
    pe = ex(b, a, 2'b00, 0);
    apb(0, PROD_LO_ADDR, 0, {1'b0, pe[31:0]});
    apb(0, PROD_HI_ADDR, 0, {1'b0, 23'h0, pe[36], 4'h0, pe[35:32]});
    apb(0, OPND_ADDR, 0, 33'h0);
    $display("test hold and clear done");
    conclude(0);
  end
endmodule
`default_nettype wire
